// ===== sbs_mem_model.sv
// Memory subsystem model: 256 bytes, one access at a time, set latency.
// Assumes the unit holds its request until acknowledged.
`timescale 1ns/10ps
`default_nettype none
module sbs_mem_model
  import sbs_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_nrst,
  // Request side
  input  wire sbs_pkg::sbs_mem_req_type i_mem,
  input  wire logic [3:0]               i_lat,
  // Answer side
  output logic                          o_ack,
  output logic [15:0]                   o_rdata
);
  logic [7:0] mem_ff [256];
  logic [3:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < 256; k++) mem_ff[k] <= 8'(k) ^ 8'h5a;
      cnt_ff  <= 4'h0;
      o_ack   <= 1'b0;
      o_rdata <= 16'h0;
    end else if (i_mem.req && !o_ack && cnt_ff == i_lat) begin
      o_ack   <= 1'b1;
      cnt_ff  <= 4'h0;
      o_rdata <= {mem_ff[i_mem.addr[7:0]], mem_ff[i_mem.addr[7:0] + 8'h1]};
      if (i_mem.we) mem_ff[i_mem.addr[7:0]] <= i_mem.wdata;
    end else begin
      // Data lines churn outside the answer cycle
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_mem.req && !o_ack) cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== sbs_pkg.sv
// Types shared by the short load and byte-set unit and its bench.
// Assumes sbs_regs.svh sits in the same folder.
package sbs_pkg;

  typedef enum logic [2:0] {
    SBS_TRAP_NONE     = 3'h0,
    SBS_TRAP_ILLEGAL  = 3'h1,
    SBS_TRAP_FP_OFF   = 3'h2,
    SBS_TRAP_ALIGN    = 3'h3,
    SBS_TRAP_PRIV     = 3'h4,
    SBS_TRAP_DACCESS  = 3'h5
  } sbs_trap_type;

  typedef enum logic [3:0] {
    SBS_ST_IDLE  = 4'b0001,
    SBS_ST_READ  = 4'b0010,
    SBS_ST_WRITE = 4'b0100,
    SBS_ST_DONE  = 4'b1000
  } sbs_state_type;

  // Request to the memory subsystem
  typedef struct packed {
    logic        req;
    logic        we;
    logic        lock;
    logic        half;
    logic [7:0]  asi;
    logic [63:0] addr;
    logic [7:0]  wdata;
  } sbs_mem_req_type;

  // Writeback toward the register files
  typedef struct packed {
    logic        int_we;
    logic        fp_we;
    logic [4:0]  rd;
    logic [63:0] data;
  } sbs_wb_type;

endpackage

// ===== sbs_regs.svh
// Register offsets, field positions, reset values and space codes for the
// short floating-point load and atomic byte-set unit.
// Assumes inclusion by bare name from the unit, the checker and the bench.
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

// APB register byte offsets
`define SBS_CTRL_OFF        12'h000
`define SBS_STATUS_OFF      12'h004
`define SBS_TRAPCNT_OFF     12'h008
`define SBS_DONECNT_OFF     12'h00c
`define SBS_CTRL_RST        32'h0000_0000
`define SBS_CTRL_SHORT_HW   0
`define SBS_CTRL_LOCK_HOLD  1

// Instruction fields
`define SBS_OP_MEM          2'h3
`define SBS_OP3_BYTESET     6'h0d
`define SBS_OP3_BYTESET_ALT 6'h1d
`define SBS_OP3_DFA         6'h33

// Short load space codes
`define SBS_ASI_FL8_PRI     8'hd0
`define SBS_ASI_FL8_S       8'hd1
`define SBS_ASI_FL16_PRI    8'hd2
`define SBS_ASI_FL16_S      8'hd3
`define SBS_ASI_FL8_PL      8'hd8
`define SBS_ASI_FL8_SL      8'hd9
`define SBS_ASI_FL16_PL     8'hda
`define SBS_ASI_FL16_SL     8'hdb

// Spaces accepted by the alternate byte-set, privileged range bounds and implicit space
`define SBS_ASI_NUC         8'h04
`define SBS_ASI_NUC_L       8'h0c
`define SBS_ASI_AIUP        8'h10
`define SBS_ASI_AIUS        8'h11
`define SBS_ASI_AIUP_L      8'h18
`define SBS_ASI_AIUS_L      8'h19
`define SBS_ASI_REAL        8'h14
`define SBS_ASI_REAL_L      8'h1c
`define SBS_ASI_PRI         8'h80
`define SBS_ASI_SEC         8'h81
`define SBS_ASI_PRI_L       8'h88
`define SBS_ASI_SEC_L       8'h89
`define SBS_ASI_PRIV_LO     8'h30
`define SBS_ASI_PRIV_HI     8'h7f
`define SBS_ASI_IMPLICIT    8'h80

`endif

// ===== sbs_unit.sv
// Short floating-point load and atomic byte-set execution unit.
// Assumes one core clock, a memory port that answers with i_mem_ack and
// an APB master on the same clock.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"

// Behaviour
// - Short load fills 64-bit fp register
// - Fpu_off_trap or absent raises fpu_off_trap
// - Byte load zero-fills upper bytes
// - Byte load never misaligned
// - Halfword load zero-fills upper part
// - Odd halfword address traps misaligned
// - Little-endian spaces swap fetched bytes
// - D0 D1 D8 D9 select byte loads
// - D2 D3 select halfword loads
// - Shared opcode split by space only
// - Short loads trap as data access; here only while CTRL bit 0 is clear
// - Byte-set reads byte, writes ones
// - Fetched byte right-justified, zero-filled
// - Read and write are one atomic pair
// - Atomics to one doubleword are serialized
// - Address is sum or signed offset
// - Register form needs bits 12:5 zero
// - Alternate form is op 11, 011101
// - Space from field or space register
// - User mode needs space bit 7 set
// - Privileged mode rejects spaces 30-7F
// - Only listed spaces, else data access
module sbs_unit (
  // Clock and reset
  input  wire  logic                    I_SYS_CLK,
  input  wire  logic                    I_NRST,
  // Instruction issue
  input  wire  logic                    I_INSTR_VALID,
  output logic                          O_INSTR_READY,
  input  wire  logic [31:0]             I_INSTR,
  input  wire  logic [63:0]             I_SRC1_VAL,
  input  wire  logic [63:0]             I_SRC2_VAL,
  // Processor state
  input  wire  logic [7:0]              I_ASI_REG,
  input  wire  logic                    I_PRIVILEGED_MODE_BIT,
  input  wire  logic                    I_FP_REGS_ENABLE_BIT,
  input  wire  logic                    I_FPU_ENABLE_BIT,
  input  wire  logic                    I_FPU_PRESENT,
  // Memory port
  output sbs_pkg::sbs_mem_req_type      O_MEM,
  input  wire  logic                    I_MEM_ACK,
  input  wire  logic [15:0]             I_MEM_RDATA,
  // Completion
  output var   sbs_pkg::sbs_wb_type     O_WB,
  output logic                          O_DONE,
  output logic                          O_UNCLAIMED,
  output logic                          O_TRAP,
  output sbs_pkg::sbs_trap_type         O_TRAP_CAUSE,
  // APB slave
  input  wire  logic                    PSEL,
  input  wire  logic                    PENABLE,
  input  wire  logic                    PWRITE,
  input  wire  logic [11:0]             PADDR,
  input  wire  logic [31:0]             PWDATA,
  output logic [31:0]                   PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR
);
  import sbs_pkg::*;
  sbs_state_type   state_ff;
  sbs_state_type   nxt_state;
  sbs_mem_req_type mem_ff;
  sbs_wb_type      wb_ff;
  logic            done_ff;
  logic            unclaimed_ff;
  logic            trap_ff;
  sbs_trap_type    cause_ff;
  logic            is_int_ff;
  logic            little_ff;
  logic [4:0]      rd_ff;
  logic [31:0]     ctrl_ff;
  logic [15:0]     trap_cnt_ff;
  logic [15:0]     done_cnt_ff;
  logic [31:0]     prdata_ff;
  sbs_trap_type    last_cause_ff;

  // Decode
  logic        is_mem_op;
  logic [5:0]  op3;
  logic        imm_sel;
  logic [4:0]  rd_field;
  logic [7:0]  imm_asi;
  logic [63:0] simm_ext;
  logic [63:0] eff_addr;
  logic [7:0]  chosen_asi;
  logic        is_byteset;
  logic        is_byteset_alt;
  logic        is_dfa_op;
  logic        is_short;
  logic        short_half;
  logic        short_little;
  logic        asi_listed;
  logic        asi_little;
  logic        take;
  sbs_trap_type trap_sel;

  assign is_mem_op = (I_INSTR[31:30] == `SBS_OP_MEM);
  assign op3       = I_INSTR[24:19];
  assign imm_sel   = I_INSTR[13];
  assign rd_field  = I_INSTR[29:25];
  assign imm_asi   = I_INSTR[12:5];
  assign simm_ext  = {{51{I_INSTR[12]}}, I_INSTR[12:0]};
  assign eff_addr = imm_sel ? (I_SRC1_VAL + simm_ext) : (I_SRC1_VAL + I_SRC2_VAL);
  assign is_byteset     = is_mem_op && (op3 == `SBS_OP3_BYTESET);
  assign is_byteset_alt = is_mem_op && (op3 == `SBS_OP3_BYTESET_ALT);
  assign is_dfa_op      = is_mem_op && (op3 == `SBS_OP3_DFA);
  assign chosen_asi = imm_sel ? I_ASI_REG : imm_asi;
  // Short load claimed by space code alone
  always_comb begin
    is_short     = 1'b0;
    short_half   = 1'b0;
    short_little = 1'b0;
    if (is_dfa_op) begin
      unique case (chosen_asi)
        `SBS_ASI_FL8_PRI, `SBS_ASI_FL8_S: begin
          is_short = 1'b1;
        end
        `SBS_ASI_FL8_PL, `SBS_ASI_FL8_SL: begin
          is_short     = 1'b1;
          short_little = 1'b1;
        end
        `SBS_ASI_FL16_PRI, `SBS_ASI_FL16_S: begin
          is_short   = 1'b1;
          short_half = 1'b1;
        end
        `SBS_ASI_FL16_PL, `SBS_ASI_FL16_SL: begin
          is_short     = 1'b1;
          short_half   = 1'b1;
          short_little = 1'b1;
        end
        default: is_short = 1'b0;
      endcase
    end
  end
  // Accepted spaces for the alternate byte-set
  always_comb begin
    asi_listed = 1'b1;
    asi_little = 1'b0;
    unique case (chosen_asi)
      `SBS_ASI_NUC, `SBS_ASI_AIUP, `SBS_ASI_AIUS, `SBS_ASI_REAL,
      `SBS_ASI_PRI, `SBS_ASI_SEC: begin
        asi_little = 1'b0;
      end
      `SBS_ASI_NUC_L, `SBS_ASI_AIUP_L, `SBS_ASI_AIUS_L, `SBS_ASI_REAL_L,
      `SBS_ASI_PRI_L, `SBS_ASI_SEC_L: begin
        asi_little = 1'b1;
      end
      default: asi_listed = 1'b0;
    endcase
  end
  // Exception priority: encoding, fp, alignment, privilege, space
  always_comb begin
    trap_sel = SBS_TRAP_NONE;
    if (is_byteset) begin
      if (!imm_sel && (imm_asi != 8'h00)) begin
        trap_sel = SBS_TRAP_ILLEGAL;
      end
    end else if (is_byteset_alt) begin
      if (!I_PRIVILEGED_MODE_BIT && !chosen_asi[7]) begin
        trap_sel = SBS_TRAP_PRIV;
      end else if (I_PRIVILEGED_MODE_BIT && (chosen_asi >= `SBS_ASI_PRIV_LO) &&
                   (chosen_asi <= `SBS_ASI_PRIV_HI)) begin
        trap_sel = SBS_TRAP_PRIV;
      end else if (!asi_listed) begin
        trap_sel = SBS_TRAP_DACCESS;
      end
    end else if (is_short) begin
      if (!I_FP_REGS_ENABLE_BIT || !I_FPU_ENABLE_BIT || !I_FPU_PRESENT) begin
        trap_sel = SBS_TRAP_FP_OFF;
      end else if (short_half && eff_addr[0]) begin
        trap_sel = SBS_TRAP_ALIGN;
      end else if (!ctrl_ff[`SBS_CTRL_SHORT_HW]) begin
        trap_sel = SBS_TRAP_DACCESS;
      end
    end
  end
  assign O_INSTR_READY = (state_ff == SBS_ST_IDLE);
  assign take          = I_INSTR_VALID && O_INSTR_READY;
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SBS_ST_IDLE: begin
        // A trapping instruction never reaches memory
        if (take && (trap_sel == SBS_TRAP_NONE) &&
            (is_byteset || is_byteset_alt || is_short)) begin
          nxt_state = SBS_ST_READ;
        end
      end
      SBS_ST_READ: begin
        if (I_MEM_ACK) begin
          nxt_state = is_int_ff ? SBS_ST_WRITE : SBS_ST_DONE;
        end
      end
      SBS_ST_WRITE: begin
        if (I_MEM_ACK) begin
          nxt_state = SBS_ST_DONE;
        end
      end
      SBS_ST_DONE: begin
        nxt_state = SBS_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_ff <= SBS_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // Captured instruction context
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      is_int_ff <= 1'b0;
      little_ff <= 1'b0;
      rd_ff     <= 5'h00;
    end else if (take) begin
      is_int_ff <= is_byteset || is_byteset_alt;
      little_ff <= is_short ? short_little : (is_byteset_alt && asi_little);
      rd_ff     <= rd_field;
    end
  end
  // Memory request
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mem_ff <= '0;
    end else begin
      unique case (state_ff)
        SBS_ST_IDLE: begin
          if (nxt_state == SBS_ST_READ) begin
            mem_ff.req   <= 1'b1;
            mem_ff.we    <= 1'b0;
            mem_ff.addr  <= eff_addr;
            mem_ff.half  <= is_short && short_half;
            mem_ff.asi   <= is_byteset ? `SBS_ASI_IMPLICIT : chosen_asi;
            mem_ff.wdata <= 8'h00;
            // Lock held from read to write
            mem_ff.lock  <= is_byteset || is_byteset_alt;
          end
        end
        SBS_ST_READ: begin
          if (I_MEM_ACK && is_int_ff) begin
            mem_ff.we    <= 1'b1;
            mem_ff.wdata <= 8'hff;
          end else if (I_MEM_ACK) begin
            mem_ff <= '0;
          end
        end
        SBS_ST_WRITE: begin
          if (I_MEM_ACK) begin
            mem_ff <= '0;
          end
        end
        SBS_ST_DONE: begin
          mem_ff <= '0;
        end
      endcase
    end
  end
  assign O_MEM = mem_ff;

  // Read data formatting; memory returns the byte at addr in [15:8]
  logic [63:0] fetched;
  always_comb begin
    fetched = 64'h0;
    if (mem_ff.half) begin
      // Halfword in low bits, rest zero
      fetched[15:0] = little_ff ? {I_MEM_RDATA[7:0], I_MEM_RDATA[15:8]} : I_MEM_RDATA;
    end else begin
      fetched[7:0] = I_MEM_RDATA[15:8];
    end
  end

  // Writeback
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wb_ff <= '0;
    end else if ((state_ff == SBS_ST_READ) && I_MEM_ACK) begin
      wb_ff.data   <= fetched;
      wb_ff.rd     <= rd_ff;
      wb_ff.int_we <= 1'b0;
      wb_ff.fp_we  <= !is_int_ff;
    end else if (nxt_state == SBS_ST_DONE && state_ff != SBS_ST_DONE) begin
      // Commit only after the atomic pair has finished
      wb_ff.int_we <= is_int_ff;
      wb_ff.fp_we  <= !is_int_ff;
    end else begin
      wb_ff.int_we <= 1'b0;
      wb_ff.fp_we  <= 1'b0;
    end
  end
  assign O_WB = wb_ff;

  // Completion and trap pulses
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      done_ff      <= 1'b0;
      unclaimed_ff <= 1'b0;
      trap_ff      <= 1'b0;
      cause_ff     <= SBS_TRAP_NONE;
    end else begin
      done_ff      <= 1'b0;
      unclaimed_ff <= 1'b0;
      trap_ff      <= 1'b0;
      if (take && (trap_sel != SBS_TRAP_NONE)) begin
        trap_ff  <= 1'b1;
        cause_ff <= trap_sel;
      end else if (take && !(is_byteset || is_byteset_alt || is_short)) begin
        // Block and double alternate loads belong elsewhere
        unclaimed_ff <= 1'b1;
      end else if (state_ff == SBS_ST_DONE) begin
        done_ff  <= 1'b1;
        cause_ff <= SBS_TRAP_NONE;
      end
    end
  end
  assign O_DONE       = done_ff;
  assign O_UNCLAIMED  = unclaimed_ff;
  assign O_TRAP       = trap_ff;
  assign O_TRAP_CAUSE = cause_ff;
  // Statistics
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      trap_cnt_ff   <= 16'h0000;
      done_cnt_ff   <= 16'h0000;
      last_cause_ff <= SBS_TRAP_NONE;
    end else begin
      if (trap_ff) begin
        trap_cnt_ff   <= trap_cnt_ff + 16'h0001;
        last_cause_ff <= cause_ff;
      end
      if (done_ff) begin
        done_cnt_ff <= done_cnt_ff + 16'h0001;
      end
    end
  end
  // APB slave: zero wait states, read data latched in the setup cycle, CTRL written in the access cycle
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  assign apb_setup = PSEL && !PENABLE;
  assign apb_write = PSEL && PENABLE && PWRITE;
  assign addr_ok   = PADDR inside {`SBS_CTRL_OFF, `SBS_STATUS_OFF, `SBS_TRAPCNT_OFF,
                                   `SBS_DONECNT_OFF};
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_ff <= `SBS_CTRL_RST;
    end else if (apb_write && (PADDR == `SBS_CTRL_OFF)) begin
      ctrl_ff <= {30'h0, PWDATA[1:0]};
    end
  end
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      prdata_ff <= 32'h0000_0000;
    end else if (apb_setup) begin
      unique case (PADDR)
        `SBS_CTRL_OFF:    prdata_ff <= ctrl_ff;
        `SBS_STATUS_OFF:  prdata_ff <= {21'h0, last_cause_ff, 4'(state_ff), 4'h0};
        `SBS_TRAPCNT_OFF: prdata_ff <= {16'h0, trap_cnt_ff};
        `SBS_DONECNT_OFF: prdata_ff <= {16'h0, done_cnt_ff};
        default:          prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign PRDATA  = prdata_ff;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

endmodule
`default_nettype wire

// ===== sbs_unit_props.sv
// Port-level checker for the short load and atomic byte-set unit.
// Assumes sbs_pkg is compiled first; bound onto every sbs_unit.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"
module sbs_unit_props
  import sbs_pkg::*;
(
  input wire logic                    I_SYS_CLK,
  input wire logic                    I_NRST,
  input wire logic                    I_INSTR_VALID,
  input wire logic                    O_INSTR_READY,
  input wire logic [31:0]             I_INSTR,
  input wire logic [7:0]              I_ASI_REG,
  input wire logic                    I_PRIVILEGED_MODE_BIT,
  input wire sbs_pkg::sbs_mem_req_type O_MEM,
  input wire logic                    I_MEM_ACK,
  input wire sbs_pkg::sbs_wb_type     O_WB,
  input wire logic                    O_DONE,
  input wire logic                    O_TRAP,
  input wire sbs_pkg::sbs_trap_type   O_TRAP_CAUSE
);
  logic       taken;
  logic       alt_set;
  logic [7:0] asi_sel;
  assign taken   = I_INSTR_VALID && O_INSTR_READY && I_INSTR[31:30] == 2'h3;
  assign alt_set = taken && I_INSTR[24:19] == `SBS_OP3_BYTESET_ALT;
  assign asi_sel = I_INSTR[13] ? I_ASI_REG : I_INSTR[12:5];
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  property p_trap_quiet;
    O_TRAP |-> !O_WB.int_we && !O_WB.fp_we && !O_MEM.req;
  endproperty
  a_trap_quiet: assert property (p_trap_quiet) else $error("trap with side effect");
  property p_req_busy;
    O_MEM.req |-> !O_INSTR_READY;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("memory access while idle");
  property p_set_ones;
    O_MEM.req && O_MEM.we |-> O_MEM.lock && O_MEM.wdata == 8'hff;
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("write not locked ones");
  property p_wr_after_rd;
    O_MEM.req && O_MEM.we && !$past(O_MEM.we) |->
      $past(O_MEM.req && !O_MEM.we && O_MEM.lock && I_MEM_ACK) && $stable(O_MEM.addr);
  endproperty
  a_wr_after_rd: assert property (p_wr_after_rd) else $error("write not after read");
  property p_lock_held;
    O_MEM.req && !O_MEM.we && O_MEM.lock && I_MEM_ACK |=> O_MEM.req && O_MEM.we && O_MEM.lock;
  endproperty
  a_lock_held: assert property (p_lock_held) else $error("locked pair broken");
  property p_done_after_wb;
    O_WB.int_we || O_WB.fp_we |=> O_DONE;
  endproperty
  a_done_after_wb: assert property (p_done_after_wb) else $error("done missing");
  property p_fp_zero;
    O_WB.fp_we |-> O_WB.data[63:16] == 48'h0;
  endproperty
  a_fp_zero: assert property (p_fp_zero) else $error("fp upper not zero");
  property p_int_zero;
    O_WB.int_we |-> O_WB.data[63:8] == 56'h0;
  endproperty
  a_int_zero: assert property (p_int_zero) else $error("int upper not zero");
  property p_half_even;
    O_MEM.req && O_MEM.half |-> !O_MEM.addr[0];
  endproperty
  a_half_even: assert property (p_half_even) else $error("odd halfword access");
  property p_illegal;
    taken && I_INSTR[24:19] == `SBS_OP3_BYTESET && !I_INSTR[13] && I_INSTR[12:5] != 8'h0
      |=> O_TRAP && O_TRAP_CAUSE == SBS_TRAP_ILLEGAL;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal form accepted");
  property p_user_priv;
    alt_set && !I_PRIVILEGED_MODE_BIT && !asi_sel[7] |=> O_TRAP && O_TRAP_CAUSE == SBS_TRAP_PRIV;
  endproperty
  a_user_priv: assert property (p_user_priv) else $error("user space check");
  property p_priv_range;
    alt_set && I_PRIVILEGED_MODE_BIT && asi_sel inside {[8'h30:8'h7f]}
      |=> O_TRAP && O_TRAP_CAUSE == SBS_TRAP_PRIV;
  endproperty
  a_priv_range: assert property (p_priv_range) else $error("privileged range check");
endmodule
bind sbs_unit sbs_unit_props sbs_unit_props_inst (.I_SYS_CLK, .I_NRST, .I_INSTR_VALID,
  .O_INSTR_READY, .I_INSTR, .I_ASI_REG, .I_PRIVILEGED_MODE_BIT, .O_MEM, .I_MEM_ACK, .O_WB,
  .O_DONE, .O_TRAP, .O_TRAP_CAUSE);
`default_nettype wire

// ===== short_fp_load_and_atomic_byte_set_tb.sv
// Self-checking bench for sbs_unit with the memory model on its port.
// Assumes sbs_pkg, the checker and the model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"
module short_fp_load_and_atomic_byte_set_tb;
  import sbs_pkg::*;
  logic I_SYS_CLK, I_NRST, I_INSTR_VALID, O_INSTR_READY, I_MEM_ACK, O_DONE, O_UNCLAIMED;
  logic I_PRIVILEGED_MODE_BIT, I_FP_REGS_ENABLE_BIT, I_FPU_ENABLE_BIT, I_FPU_PRESENT, O_TRAP;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [31:0] I_INSTR, PWDATA, PRDATA, rd;
  logic [63:0] I_SRC1_VAL, I_SRC2_VAL, wb_d, ex;
  logic [7:0]  I_ASI_REG, a;
  logic [15:0] I_MEM_RDATA;
  logic [11:0] PADDR;
  logic [3:0]  lat;
  sbs_mem_req_type O_MEM;
  sbs_wb_type      O_WB;
  sbs_trap_type    O_TRAP_CAUSE;
  int n_fail, compares, n_wr, n_wb, cyc;
  logic [7:0] shd [256];
  logic [7:0] sc [8] = '{`SBS_ASI_FL8_PRI, `SBS_ASI_FL8_S, `SBS_ASI_FL8_PL, `SBS_ASI_FL8_SL,
    `SBS_ASI_FL16_PRI, `SBS_ASI_FL16_S, `SBS_ASI_FL16_PL, `SBS_ASI_FL16_SL};
  logic [7:0] sp [12] = '{`SBS_ASI_NUC, `SBS_ASI_NUC_L, `SBS_ASI_AIUP, `SBS_ASI_AIUS,
    `SBS_ASI_AIUP_L, `SBS_ASI_AIUS_L, `SBS_ASI_REAL, `SBS_ASI_REAL_L, `SBS_ASI_PRI,
    `SBS_ASI_SEC, `SBS_ASI_PRI_L, `SBS_ASI_SEC_L};
  sbs_unit sbs_unit_inst (.I_SYS_CLK, .I_NRST, .I_INSTR_VALID, .O_INSTR_READY, .I_INSTR,
    .I_SRC1_VAL, .I_SRC2_VAL, .I_ASI_REG, .I_PRIVILEGED_MODE_BIT, .I_FP_REGS_ENABLE_BIT,
    .I_FPU_ENABLE_BIT, .I_FPU_PRESENT, .O_MEM, .I_MEM_ACK, .I_MEM_RDATA, .O_WB, .O_DONE,
    .O_UNCLAIMED, .O_TRAP, .O_TRAP_CAUSE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR);
  sbs_mem_model sbs_mem_model_inst (.i_clk(I_SYS_CLK), .i_nrst(I_NRST), .i_mem(O_MEM),
    .i_lat(lat), .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));
  initial begin
    I_SYS_CLK = 1'b0;
    forever #25 I_SYS_CLK = ~I_SYS_CLK;
  end
  // Side effects seen on the ports, for the no-change checks
  always @(posedge I_SYS_CLK) begin
    cyc++;
    if (O_MEM.req === 1'b1 && O_MEM.we === 1'b1 && I_MEM_ACK === 1'b1) n_wr++;
    if (O_WB.int_we === 1'b1 || O_WB.fp_we === 1'b1) begin
      wb_d <= O_WB.data;
      n_wb++;
    end
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge I_SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge I_SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge I_SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input logic [5:0] o3, input logic [13:0] lo);
    return {2'h3, 5'h03, o3, 5'h01, lo};
  endfunction
  // Code 0 expects completion with data, 7 a pass-over, else that trap
  task automatic run(input logic [31:0] ins, input logic [63:0] r1, input logic [63:0] r2,
      input logic [7:0] ar, input logic pv, input logic [2:0] ec, input logic [63:0] ed);
    int w0, b0, t;
    w0 = n_wr;
    b0 = n_wb;
    t = 0;
    while (O_INSTR_READY !== 1'b1) @(negedge I_SYS_CLK);
    @(posedge I_SYS_CLK);
    I_INSTR <= ins;
    I_SRC1_VAL <= r1;
    I_SRC2_VAL <= r2;
    I_ASI_REG <= ar;
    I_PRIVILEGED_MODE_BIT <= pv;
    I_INSTR_VALID <= 1'b1;
    @(posedge I_SYS_CLK);
    I_INSTR_VALID <= 1'b0;
    @(negedge I_SYS_CLK);
    while (O_DONE !== 1'b1 && O_TRAP !== 1'b1 && O_UNCLAIMED !== 1'b1 && t < 60) begin
      @(negedge I_SYS_CLK);
      t++;
    end
    if (ec == 3'h0) begin
      check(O_DONE, 1'b1);
      check(wb_d, ed);
      check(n_wr - w0, (ins[24:19] == `SBS_OP3_DFA) ? 0 : 1);
    end else if (ec == 3'h7) check(O_UNCLAIMED, 1'b1);
    else begin
      check(O_TRAP, 1'b1);
      check(O_TRAP_CAUSE, ec);
      check(n_wr - w0, 0);
      check(n_wb - b0, 0);
    end
  endtask
  initial begin
    {I_NRST, I_INSTR_VALID, PSEL, PENABLE, PWRITE, I_PRIVILEGED_MODE_BIT} = 6'h0;
    {I_FP_REGS_ENABLE_BIT, I_FPU_ENABLE_BIT, I_FPU_PRESENT} = 3'h7;
    {I_INSTR, PWDATA, PADDR, I_ASI_REG, lat} = '0;
    {I_SRC1_VAL, I_SRC2_VAL} = '0;
    for (int k = 0; k < 256; k++) shd[k] = 8'(k) ^ 8'h5a;
    repeat (2) @(posedge I_SYS_CLK);
    I_NRST <= 1'b1;
    apb(1'b0, `SBS_CTRL_OFF, 32'h0);
    check(rd, `SBS_CTRL_RST);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    check(er, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    run(mk(`SBS_OP3_DFA, {1'b0, `SBS_ASI_FL8_PRI, 5'h0}), 64'h20, 0, 0, 1, SBS_TRAP_DACCESS, 0);
    for (int k = 0; k < 3; k++) begin
      @(posedge I_SYS_CLK);
      {I_FP_REGS_ENABLE_BIT, I_FPU_ENABLE_BIT, I_FPU_PRESENT} <= ~(3'h1 << k);
      run(mk(`SBS_OP3_DFA, {1'b0, `SBS_ASI_FL8_PRI, 5'h0}), 64'h20, 0, 0, 1, SBS_TRAP_FP_OFF, 0);
    end
    @(posedge I_SYS_CLK);
    {I_FP_REGS_ENABLE_BIT, I_FPU_ENABLE_BIT, I_FPU_PRESENT} <= 3'h7;
    apb(1'b1, `SBS_CTRL_OFF, 32'h1);
    for (int k = 0; k < 8; k++) begin
      a = 8'h20 + 8'(2 * k);
      ex = (k < 4) ? {56'h0, shd[a]} : (k < 6) ? {48'h0, shd[a], shd[a + 8'h1]}
         : {48'h0, shd[a + 8'h1], shd[a]};
      run(mk(`SBS_OP3_DFA, {1'b0, sc[k], 5'h2}), 64'h20, 64'(2 * k), 0, 1, 0, ex);
    end
    run(mk(`SBS_OP3_DFA, {1'b0, `SBS_ASI_FL16_PRI, 5'h0}), 64'h21, 0, 0, 1, SBS_TRAP_ALIGN, 0);
    run(mk(`SBS_OP3_DFA, {1'b0, `SBS_ASI_FL8_PRI, 5'h0}), 64'h21, 0, 0, 1, 0, {56'h0, shd[8'h21]});
    run(mk(`SBS_OP3_DFA, {1'b0, 8'h80, 5'h0}), 64'h20, 0, 0, 1, 3'h7, 0);
    // Slow memory from here on, to stretch the locked pair
    @(posedge I_SYS_CLK);
    lat <= 4'h3;
    run(mk(`SBS_OP3_BYTESET, 14'h3ffd), 64'h40, 0, 0, 0, 0, {56'h0, shd[8'h3d]});
    run(mk(`SBS_OP3_BYTESET, 14'h3ffd), 64'h40, 0, 0, 0, 0, 64'hff);
    run(mk(`SBS_OP3_BYTESET, 14'h0000), 64'h40, 64'h8, 0, 0, 0, {56'h0, shd[8'h48]});
    run(mk(`SBS_OP3_BYTESET, 14'h0020), 64'h40, 64'h9, 0, 0, SBS_TRAP_ILLEGAL, 0);
    for (int k = 0; k < 12; k++) begin
      a = 8'h60 + 8'(k);
      run(mk(`SBS_OP3_BYTESET_ALT, {1'b0, sp[k], 5'h0}), 64'h60, 64'(k), 0, 1, 0, {56'h0, shd[a]});
    end
    run(mk(`SBS_OP3_BYTESET_ALT, {1'b0, 8'h80, 5'h0}), 64'h70, 0, 0, 0, 0, {56'h0, shd[8'h70]});
    run(mk(`SBS_OP3_BYTESET_ALT, 14'h2000), 64'h71, 0, 8'h04, 0, SBS_TRAP_PRIV, 0);
    run(mk(`SBS_OP3_BYTESET_ALT, 14'h2000), 64'h72, 0, 8'h30, 1, SBS_TRAP_PRIV, 0);
    run(mk(`SBS_OP3_BYTESET_ALT, 14'h2000), 64'h73, 0, 8'h7f, 1, SBS_TRAP_PRIV, 0);
    run(mk(`SBS_OP3_BYTESET_ALT, 14'h2000), 64'h74, 0, 8'h82, 1, SBS_TRAP_DACCESS, 0);
    run(mk(`SBS_OP3_BYTESET_ALT, 14'h2000), 64'h75, 0, 8'h81, 1, 0, {56'h0, shd[8'h75]});
    conclude();
  end
endmodule
`default_nettype wire
